// ### rate_sensor_spi_frame_port.v
`timescale 1ns/100ps
`include "rate_frame_defs.vh"
module rate_sensor_spi_frame_port #(
  parameter SAMPLE_W = 12
) (
  input  wire                ref_clk_i,
  input  wire                rst_i,
  input  wire                cs_n_i,
  input  wire                sclk_i,
  input  wire                din_i,
  output reg                 dout_o,
  output reg                 dout_oe_n_o,
  input  wire [SAMPLE_W-1:0] rate_sample_i,
  input  wire [SAMPLE_W-1:0] temp_sample_i,
  input  wire [SAMPLE_W-1:0] aux_analog_in_a_i,
  input  wire [SAMPLE_W-1:0] aux_analog_in_b_i,
  output reg                 hold_o,
  output reg  [1:0]          source_sel_o,
  output reg                 offset_binary_o,
  output reg                 sample_valid_o,
  output reg  [15:0]         sample_word_o,
  input  wire                sample_ready_i
);

  localparam ST_IDLE  = 2'b01;
  localparam ST_FRAME = 2'b10;

  // Analog samples are twos complement; offset binary flips the sign bit.
  function [SAMPLE_W-1:0] code_sample;
    input [SAMPLE_W-1:0] raw;
    input                offs;
    begin
      code_sample = offs ? (raw ^ `OFFSET_BIN_FLIP) : raw;
    end
  endfunction

  reg [2:0] cs_sync_reg;
  reg [2:0] ck_sync_reg;
  reg [2:0] di_sync_reg;
  reg       cs_lvl_reg;
  reg       ck_lvl_reg;
  reg [1:0] state_reg;
  reg [4:0] edge_cnt_reg;
  reg [15:0] tx_shift_reg;
  reg [15:0] rx_shift_reg;
  reg [SAMPLE_W-1:0] held_reg;
  reg [1:0] held_src_reg;
  reg [15:0] next_word_reg;
  reg [15:0] buf_data_reg [0:1];
  reg [1:0] buf_cnt_reg;
  reg       buf_wr_reg;
  reg       buf_rd_reg;

  wire cs_stable = (cs_sync_reg[2] == cs_sync_reg[1]);
  wire ck_stable = (ck_sync_reg[2] == ck_sync_reg[1]);
  wire cs_fall   = cs_stable & cs_lvl_reg & ~cs_sync_reg[2];
  wire cs_rise   = cs_stable & ~cs_lvl_reg & cs_sync_reg[2];
  wire ck_fall   = ck_stable & ck_lvl_reg & ~ck_sync_reg[2];
  wire [15:0] full_rx = {rx_shift_reg[14:0], di_sync_reg[2]};
  wire [15:0] cap_word = {2'b00, held_src_reg, code_sample(held_reg, offset_binary_o)};
  wire        buf_push = cs_rise && (edge_cnt_reg == `FRAME_BITS);
  wire        buf_pop  = sample_valid_o && sample_ready_i;
  wire        buf_full = (buf_cnt_reg == 2'h2);
  wire        buf_take = buf_push && !buf_full;

  reg [1:0]  buf_cnt_next;
  reg        buf_rd_next;
  reg [15:0] head_next;

  // The head word is taken from the next state, so a word pushed into an empty buffer is shown at once.
  always @* begin
    buf_cnt_next = buf_cnt_reg + {1'b0, buf_take} - {1'b0, buf_pop};
    buf_rd_next  = buf_pop ? ~buf_rd_reg : buf_rd_reg;
    if ((buf_cnt_reg - {1'b0, buf_pop}) == 2'h0) begin
      head_next = cap_word;
    end else begin
      head_next = buf_data_reg[buf_rd_next];
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      cs_sync_reg <= 3'h7;
      ck_sync_reg <= 3'h7;
      di_sync_reg <= 3'h0;
      cs_lvl_reg  <= 1'b1;
      ck_lvl_reg  <= 1'b1;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n_i};
      ck_sync_reg <= {ck_sync_reg[1:0], sclk_i};
      di_sync_reg <= {di_sync_reg[1:0], din_i};
      if (cs_stable) begin
        cs_lvl_reg <= cs_sync_reg[2];
      end
      if (ck_stable) begin
        ck_lvl_reg <= ck_sync_reg[2];
      end
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg       <= ST_IDLE;
      edge_cnt_reg    <= 5'h0;
      tx_shift_reg    <= 16'h0000;
      rx_shift_reg    <= 16'h0000;
      dout_o          <= 1'b0;
      dout_oe_n_o     <= 1'b1;
      hold_o          <= 1'b0;
      held_reg        <= {SAMPLE_W{1'b0}};
      held_src_reg    <= `CTL_SRC_RESET;
      source_sel_o    <= `CTL_SRC_RESET;
      offset_binary_o <= `CTL_CODE_RESET;
      next_word_reg   <= 16'h0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          dout_oe_n_o <= 1'b1;
          if (cs_fall) begin
            state_reg    <= ST_FRAME;
            edge_cnt_reg <= 5'h0;
            hold_o       <= 1'b1;
            // The frame shifts out the word built at the end of the last full frame.
            tx_shift_reg <= {next_word_reg[14:0], 1'b0};
            dout_o       <= next_word_reg[15];
            dout_oe_n_o  <= 1'b0;
            case (source_sel_o)
              `SRC_RATE:  held_reg <= rate_sample_i;
              `SRC_TEMP:  held_reg <= temp_sample_i;
              `SRC_AUX_A: held_reg <= aux_analog_in_a_i;
              default:    held_reg <= aux_analog_in_b_i;
            endcase
            held_src_reg <= source_sel_o;
          end
        end
        ST_FRAME: begin
          if (cs_rise) begin
            state_reg   <= ST_IDLE;
            dout_oe_n_o <= 1'b1;
            hold_o      <= 1'b0;
            if (edge_cnt_reg == `FRAME_BITS) begin
              next_word_reg <= cap_word;
              if (rx_shift_reg[`CTL_WRITE_BIT]) begin
                source_sel_o    <= rx_shift_reg[`CTL_SRC_HI_BIT:`CTL_SRC_LO_BIT];
                offset_binary_o <= rx_shift_reg[`CTL_CODE_BIT];
              end
            end
          end else if (ck_fall && edge_cnt_reg < `FRAME_BITS) begin
            edge_cnt_reg <= edge_cnt_reg + 5'h1;
            rx_shift_reg <= full_rx;
            dout_o       <= tx_shift_reg[15];
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
            if (edge_cnt_reg == 5'hF) begin
              dout_oe_n_o <= 1'b1;
            end
            if (edge_cnt_reg == 5'hD) begin
              hold_o <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Two-entry buffer of completed frame words; a full buffer drops no held entry.
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      buf_cnt_reg     <= 2'h0;
      buf_wr_reg      <= 1'b0;
      buf_rd_reg      <= 1'b0;
      sample_valid_o  <= 1'b0;
      sample_word_o   <= 16'h0000;
      buf_data_reg[0] <= 16'h0000;
      buf_data_reg[1] <= 16'h0000;
    end else begin
      if (buf_take) begin
        buf_data_reg[buf_wr_reg] <= cap_word;
        buf_wr_reg <= ~buf_wr_reg;
      end
      buf_rd_reg     <= buf_rd_next;
      buf_cnt_reg    <= buf_cnt_next;
      sample_valid_o <= (buf_cnt_next != 2'h0);
      sample_word_o  <= head_next;
    end
  end

endmodule

// ### rate_frame_defs.vh
// Contract
// - Output drives zero when select falls, second zero after first falling clock.
// - Then fourteen bits on falling edges: source tag, then twelve sample bits.
// - Output released to high impedance after the sixteenth falling clock edge.
// - Input bit 15 set loads the word into control settings; clear leaves them.
// - Input bits 11:10 pick source: rate, temperature, auxiliary a, auxiliary b.
// - Input bit 4 picks coding: zero twos complement, one offset binary.
// - Twos-complement rate sample: zero rate is code zero, negatives negative.
// - Offset-binary sample equals twos-complement value plus 2048.
// - Temperature reads code zero at 25 degrees in twos complement.
// - Auxiliary offset-binary sample steps one code per converter step.
// - While select is high, output released and input and clock ignored.
// - Input sampled on falling clock; settings change only after full frame.
// - Short frame keeps old settings and keeps the old output sample.
// - Sample taken when select falls; tracking resumes on fourteenth falling edge.
`ifndef RATE_FRAME_DEFS_VH
`define RATE_FRAME_DEFS_VH
`define FRAME_BITS        16
`define SAMPLE_BITS       12
`define CTL_WRITE_BIT     15
`define CTL_SRC_HI_BIT    11
`define CTL_SRC_LO_BIT    10
`define CTL_CODE_BIT      4
`define TRACK_EDGE        14
`define OFFSET_BIN_FLIP   12'h800
`define SRC_RATE          2'h0
`define SRC_TEMP          2'h1
`define SRC_AUX_A         2'h2
`define SRC_AUX_B         2'h3
`define CTL_SRC_RESET     2'h0
`define CTL_CODE_RESET    1'h0
`endif

// ### rate_port_chk.sv
`timescale 1ns/100ps
module rate_port_chk (
  input wire        ref_clk_i,
  input wire        rst_i,
  input wire        cs_n_i,
  input wire        dout_o,
  input wire        dout_oe_n_o,
  input wire        hold_o,
  input wire [1:0]  source_sel_o,
  input wire        offset_binary_o,
  input wire        sample_valid_o,
  input wire [15:0] sample_word_o,
  input wire        sample_ready_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_idle_float: assert property (cs_n_i [*8] |-> dout_oe_n_o && !hold_o) else $error("active while idle");
  chk_first_zero: assert property ($fell(dout_oe_n_o) |-> !dout_o) else $error("first bit set");
  chk_hold_start: assert property ($fell(dout_oe_n_o) |-> ##[0:2] hold_o) else $error("no hold");
  chk_oe_release: assert property ($fell(hold_o) && !cs_n_i |->
    !dout_oe_n_o [*8] ##1 !dout_oe_n_o [*5] ##[1:5] dout_oe_n_o) else $error("release off");
  chk_idle_oe: assert property ($rose(cs_n_i) |-> ##[1:8] dout_oe_n_o) else $error("no release");
  chk_cfg_stable: assert property (!cs_n_i [*8] |-> $stable({source_sel_o, offset_binary_o})) else $error("cfg moved");
  chk_word_hold: assert property (sample_valid_o && !sample_ready_i |=> sample_valid_o && $stable(sample_word_o))
    else $error("word lost");
  chk_lead_zero: assert property (sample_valid_o |-> sample_word_o[15:14] == 2'h0) else $error("lead bits");
endmodule

// ### host_ctl.sv
`timescale 1ns/100ps
module host_ctl (
  input  wire ref_clk_i,
  input  wire dout_i,
  output reg  cs_n_o,
  output reg  sclk_o,
  output reg  din_o
);
  initial begin
    cs_n_o = 1'h1;
    sclk_o = 1'h1;
    din_o = 1'h0;
  end
  // Clock idles high; data changes on rising edges and is read just before each fall.
  task automatic frame(input [15:0] tx, input int n, output logic [15:0] rx);
    int k;
    rx = 16'h0000;
    cs_n_o = 1'h0;
    din_o = tx[15];
    repeat (8) @(negedge ref_clk_i);
    for (k = 0; k < n; k++) begin
      rx = {rx[14:0], dout_i};
      sclk_o = 1'h0;
      repeat (4) @(negedge ref_clk_i);
      sclk_o = 1'h1;
      din_o = (k < 15) ? tx[14-k] : ~din_o;
      repeat (4) @(negedge ref_clk_i);
    end
    repeat (4) @(negedge ref_clk_i);
    cs_n_o = 1'h1;
    din_o = ~din_o;
    repeat (12) @(negedge ref_clk_i);
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        ref_clk_i = 1'h0, rst_i = 1'h1, sample_ready_i = 1'h0, stall = 1'h0, code = 1'h0;
  logic [1:0]  src = 2'h0;
  logic [11:0] smp [4] = '{default: 12'h000};
  logic [15:0] rx, last_w = 16'h0000, q [$];
  int          fails = 0, checked = 0, i;
  wire         cs_n_i, sclk_i, din_i, dout_o, dout_oe_n_o, hold_o, offset_binary_o, sample_valid_o;
  wire [1:0]   source_sel_o;
  wire [15:0]  sample_word_o;
  wire [11:0]  rate_sample_i = smp[0], temp_sample_i = smp[1], aux_analog_in_a_i = smp[2], aux_analog_in_b_i = smp[3];
  always #50 ref_clk_i = ~ref_clk_i;
  rate_sensor_spi_frame_port uut (.*);
  host_ctl uh (.ref_clk_i(ref_clk_i), .dout_i(dout_o), .cs_n_o(cs_n_i), .sclk_o(sclk_i), .din_o(din_i));
  always @(negedge ref_clk_i) sample_ready_i <= stall ? 1'h0 : 1'($urandom);
  task automatic check(input [15:0] got, input [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge ref_clk_i)
    if (sample_valid_o === 1'h1 && sample_ready_i) check(sample_word_o, q.size() ? q.pop_front() : 16'hXXXX);
  task automatic xfer(input bit wr, input [1:0] s, input bit c, input int n);
    logic [15:0] tx, exp_w;
    tx = {wr, 1'h0, 2'($urandom), s, 2'h3, 2'($urandom), 1'h0, c, 4'($urandom)};
    foreach (smp[k]) smp[k] = 12'($urandom);
    exp_w = {2'h0, src, code ? smp[src] + 12'h800 : smp[src]};
    if (n == 16 && (!stall || q.size() < 2)) q.push_back(exp_w);
    uh.frame(tx, n, rx);
    if (n == 16) begin
      check(rx, last_w);
      last_w = exp_w;
      if (wr) {src, code} = {s, c};
    end
    check({source_sel_o, offset_binary_o}, {src, code});
  endtask
  task give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    i = $urandom(32'h6DBD765A);
    repeat (5) @(negedge ref_clk_i);
    rst_i = 1'h0;
    repeat (6) @(negedge ref_clk_i);
    for (i = 0; i < 9; i++) xfer(1'h1, i[1:0], i[2], 16);
    $display("modes test done");
    xfer(1'h0, 2'h1, 1'h0, 16);
    xfer(1'h1, 2'h3, 1'h1, 10);
    xfer(1'h0, 2'h2, 1'h1, 16);
    $display("short frame test done");
    stall = 1'h1;
    repeat (3) xfer(1'h0, 2'h0, 1'h0, 16);
    stall = 1'h0;
    for (i = 0; i < 300 && q.size() > 0; i++) @(negedge ref_clk_i);
    if (q.size() > 0) check(16'h0001, 16'h0000);
    $display("stall test done");
    give_verdict;
  end
endmodule
bind rate_sensor_spi_frame_port rate_port_chk chk (.*);
